// ### tpb_cfg.svh
// Operation
// - Count read returns counter low byte
// - Count write loads all ten bits
// - Enable bit gates counting
// - Non-stop no-reload wraps to all ones
// - Non-stop reload wraps to reload value
// - One-shot stops at zero
// - Polarity bit one means active low
// - Output enable routes waveform to pin
// - Rate field divides by two to 256
// - Disable bit high bypasses prescaler
// - Edge bit picks falling or rising edge
// - Source bit picks external or instruction
// - Reload value sets frame period
// - Duty value from high bits and duty
// - Prescaler count readable, read only
// - Buzzer field picks prescaler or timer bit
// - Buzzer enable gates buzzer output
`ifndef TPB_CFG_SVH
`define TPB_CFG_SVH

`define TPB_OFF_COUNT    8'h10
`define TPB_OFF_CTRL1    8'h11
`define TPB_OFF_CTRL2    8'h12
`define TPB_OFF_DUTY     8'h13
`define TPB_OFF_PSCNT    8'h14
`define TPB_OFF_BUZZ     8'h15
`define TPB_OFF_RLDHI    8'h17

`define TPB_C1_EN        0
`define TPB_C1_RL        1
`define TPB_C1_OS        2
`define TPB_C1_POL       6
`define TPB_C1_OEN       7

`define TPB_C2_SEL_HI    2
`define TPB_C2_PSDIS     3
`define TPB_C2_EDGE      4
`define TPB_C2_SRC       5

`define TPB_BZ_SEL_HI    3
`define TPB_BZ_EN        7

`define TPB_HI_DUTY_LO   0
`define TPB_HI_DUTY_HI   1
`define TPB_HI_RLD_LO    4
`define TPB_HI_RLD_HI    5

`define TPB_RST_CTRL2    6'h3f
`define TPB_RST_BZSEL    4'hf
`define TPB_RST_PSCNT    8'hff
`define TPB_CNT_ONES     10'h3ff
`define TPB_CNT_ZERO     10'h000

`endif

// ### tpb_pkg.sv
package tpb_pkg;

  typedef enum logic [1:0] {
    TPB_ST_RUN  = 2'b01,
    TPB_ST_DONE = 2'b10
  } tpb_state_t;

endpackage

// ### tpb_timer.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "tpb_cfg.svh"

module tpb_timer #(
  parameter int AW = 8,
  parameter int CW = 10
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr_stb,
  input  wire logic          rd_stb,
  output logic      [7:0]    rdata,
  input  wire logic          ext_clock_pin,
  input  wire logic          gpio_out,
  input  wire logic          gpio_oe,
  output logic               pwm_port_pin_o,
  output logic               pwm_port_pin_oe,
  output logic               buzzer_waveform
);

  // Divider tap: pulse when the low sel+1 bits of the
  // down-counting prescaler are zero on a source tick
  function automatic logic ps_tap(
    input logic [7:0] ps,
    input logic [2:0] sel,
    input logic       tick
  );
    logic [7:0] mask;
    mask = 8'hff >> (3'h7 - sel);
    ps_tap = tick && ((ps & mask) == 8'h00);
  endfunction

  // Register select shared by the write decode
  function automatic logic reg_hit(
    input logic [AW-1:0] a,
    input logic [7:0]    off
  );
    reg_hit = (a == AW'(off));
  endfunction

  // Register and state storage
  logic [CW-1:0]          cnt_r;
  logic [CW-1:0]          cnt_nxt;
  logic [7:0]             reload_low_r;
  logic [7:0]             reload_hi_r;
  logic [7:0]             pwm_duty_low_r;
  logic [7:0]             ps_r;
  logic [7:0]             ps_nxt;
  logic                   timer_enable_bit_r;
  logic                   reload_option_bit_r;
  logic                   one_shot_bit_r;
  logic                   pwm_polarity_bit_r;
  logic                   pwm_output_enable_bit_r;
  logic [2:0]             prescaler_rate_field_r;
  logic                   prescaler_disable_bit_r;
  logic                   ext_clock_edge_bit_r;
  logic                   clock_source_bit_r;
  logic [3:0]             buzzer_frequency_field_r;
  logic                   buzzer_enable_bit_r;
  tpb_pkg::tpb_state_t    state_r;
  tpb_pkg::tpb_state_t    state_nxt;
  logic                   ext_s1_r;
  logic                   ext_s2_r;
  logic                   ext_s3_r;
  logic                   buzz_r;
  logic                   buzz_nxt;
  logic                   tbit_prev_r;
  logic [7:0]             rdata_r;
  logic [7:0]             rdata_nxt;
  logic                   pin_o_r;
  logic                   pin_oe_r;

  // Address decode
  wire wr_count = wr_stb && reg_hit(addr, `TPB_OFF_COUNT);
  wire wr_ctrl1 = wr_stb && reg_hit(addr, `TPB_OFF_CTRL1);
  wire wr_ctrl2 = wr_stb && reg_hit(addr, `TPB_OFF_CTRL2);
  wire wr_duty  = wr_stb && reg_hit(addr, `TPB_OFF_DUTY);
  wire wr_buzz  = wr_stb && reg_hit(addr, `TPB_OFF_BUZZ);
  wire wr_rldhi = wr_stb && reg_hit(addr, `TPB_OFF_RLDHI);

  // Ten-bit reload and duty values
  wire [CW-1:0] reload_val = {
    reload_hi_r[`TPB_HI_RLD_HI:`TPB_HI_RLD_LO], reload_low_r};
  wire [CW-1:0] duty_val = {
    reload_hi_r[`TPB_HI_DUTY_HI:`TPB_HI_DUTY_LO], pwm_duty_low_r};
  wire [CW-1:0] load_val = {
    reload_hi_r[`TPB_HI_RLD_HI:`TPB_HI_RLD_LO], wdata};

  // Clock source: edge of synchronised pin or every clk
  wire ext_rise = ext_s2_r && !ext_s3_r;
  wire ext_fall = !ext_s2_r && ext_s3_r;
  wire ext_tick = ext_clock_edge_bit_r ? ext_fall : ext_rise;
  wire src_tick = clock_source_bit_r ? ext_tick : 1'b1;

  // Prescaler runs only when enabled; disabled means bypass
  wire ps_run = !prescaler_disable_bit_r && src_tick;
  wire ps_out = ps_tap(ps_r, prescaler_rate_field_r, ps_run);
  wire cnt_tick_raw = prescaler_disable_bit_r ? src_tick : ps_out;

  // Timer decrements only while enabled and not finished
  wire running = (state_r == tpb_pkg::TPB_ST_RUN);
  wire cnt_tick = timer_enable_bit_r && running && cnt_tick_raw;
  wire at_zero = (cnt_r == `TPB_CNT_ZERO);

  // Buzzer sources
  wire bz_ps_tap = ps_tap(ps_r, buzzer_frequency_field_r[2:0],
                          ps_run);
  wire bz_tbit   = cnt_r[buzzer_frequency_field_r[2:0]];
  wire bz_timer  = buzzer_frequency_field_r[`TPB_BZ_SEL_HI];
  wire bz_toggle = bz_timer ? (bz_tbit != tbit_prev_r) : bz_ps_tap;

  // PWM level
  wire pwm_active = (cnt_r < duty_val);
  wire pwm_waveform = pwm_active ^ pwm_polarity_bit_r;

  // Prescaler next value
  always_comb begin
    ps_nxt = ps_r;
    if (ps_run) begin
      ps_nxt = ps_r - 8'h01;
    end
  end

  // Counter next value and one-shot state
  always_comb begin
    cnt_nxt   = cnt_r;
    state_nxt = state_r;
    case (state_r)
      tpb_pkg::TPB_ST_RUN: begin
        if (cnt_tick) begin
          if (!at_zero) begin
            cnt_nxt = cnt_r - CW'(1);
          end else if (one_shot_bit_r) begin
            state_nxt = tpb_pkg::TPB_ST_DONE;
          end else if (reload_option_bit_r) begin
            cnt_nxt = reload_val;
          end else begin
            cnt_nxt = `TPB_CNT_ONES;
          end
        end
      end
      tpb_pkg::TPB_ST_DONE: begin
        // Parked at zero until software loads the count
        cnt_nxt = `TPB_CNT_ZERO;
      end
      default: begin
        state_nxt = tpb_pkg::TPB_ST_RUN;
      end
    endcase
    // A load in the same cycle as a tick wins
    if (wr_count) begin
      cnt_nxt   = load_val;
      state_nxt = tpb_pkg::TPB_ST_RUN;
    end
  end

  // Buzzer next value
  always_comb begin
    buzz_nxt = buzz_r;
    if (!buzzer_enable_bit_r) begin
      buzz_nxt = 1'b0;
    end else if (bz_toggle) begin
      buzz_nxt = !buzz_r;
    end
  end

  // Read data mux; duty register reads as zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (addr)
      AW'(`TPB_OFF_COUNT): begin
        rdata_nxt = cnt_r[7:0];
      end
      AW'(`TPB_OFF_CTRL1): begin
        rdata_nxt[`TPB_C1_EN]  = timer_enable_bit_r;
        rdata_nxt[`TPB_C1_RL]  = reload_option_bit_r;
        rdata_nxt[`TPB_C1_OS]  = one_shot_bit_r;
        rdata_nxt[`TPB_C1_POL] = pwm_polarity_bit_r;
        rdata_nxt[`TPB_C1_OEN] = pwm_output_enable_bit_r;
      end
      AW'(`TPB_OFF_CTRL2): begin
        rdata_nxt[`TPB_C2_SEL_HI:0] = prescaler_rate_field_r;
        rdata_nxt[`TPB_C2_PSDIS]    = prescaler_disable_bit_r;
        rdata_nxt[`TPB_C2_EDGE]     = ext_clock_edge_bit_r;
        rdata_nxt[`TPB_C2_SRC]      = clock_source_bit_r;
      end
      AW'(`TPB_OFF_PSCNT): begin
        rdata_nxt = ps_r;
      end
      AW'(`TPB_OFF_BUZZ): begin
        rdata_nxt[`TPB_BZ_SEL_HI:0] = buzzer_frequency_field_r;
        rdata_nxt[`TPB_BZ_EN]       = buzzer_enable_bit_r;
      end
      AW'(`TPB_OFF_RLDHI): begin
        rdata_nxt = reload_hi_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // External pin synchroniser; stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Done state is only left by a count write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r   <= `TPB_CNT_ZERO;
      state_r <= tpb_pkg::TPB_ST_RUN;
    end else begin
      cnt_r   <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  // Frozen, not cleared, while bypassed, so it stays readable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ps_r <= `TPB_RST_PSCNT;
    end else begin
      ps_r <= ps_nxt;
    end
  end

  // Count write also stores the low reload byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reload_low_r <= 8'h00;
    end else if (wr_count) begin
      reload_low_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reload_hi_r <= 8'h00;
    end else if (wr_rldhi) begin
      reload_hi_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwm_duty_low_r <= 8'h00;
    end else if (wr_duty) begin
      pwm_duty_low_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_enable_bit_r      <= 1'b0;
      reload_option_bit_r     <= 1'b0;
      one_shot_bit_r          <= 1'b0;
      pwm_polarity_bit_r      <= 1'b0;
      pwm_output_enable_bit_r <= 1'b0;
    end else if (wr_ctrl1) begin
      timer_enable_bit_r      <= wdata[`TPB_C1_EN];
      reload_option_bit_r     <= wdata[`TPB_C1_RL];
      one_shot_bit_r          <= wdata[`TPB_C1_OS];
      pwm_polarity_bit_r      <= wdata[`TPB_C1_POL];
      pwm_output_enable_bit_r <= wdata[`TPB_C1_OEN];
    end
  end

  // Rate changes with the prescaler running may glitch the tap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {clock_source_bit_r, ext_clock_edge_bit_r,
       prescaler_disable_bit_r, prescaler_rate_field_r}
        <= `TPB_RST_CTRL2;
    end else if (wr_ctrl2) begin
      prescaler_rate_field_r  <= wdata[`TPB_C2_SEL_HI:0];
      prescaler_disable_bit_r <= wdata[`TPB_C2_PSDIS];
      ext_clock_edge_bit_r    <= wdata[`TPB_C2_EDGE];
      clock_source_bit_r      <= wdata[`TPB_C2_SRC];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      buzzer_frequency_field_r <= `TPB_RST_BZSEL;
      buzzer_enable_bit_r      <= 1'b0;
    end else if (wr_buzz) begin
      buzzer_frequency_field_r <= wdata[`TPB_BZ_SEL_HI:0];
      buzzer_enable_bit_r      <= wdata[`TPB_BZ_EN];
    end
  end

  // Last timer bit kept for the buzzer's change detect
  always_ff @(posedge clk) begin
    if (!resetn) begin
      buzz_r      <= 1'b0;
      tbit_prev_r <= 1'b0;
    end else begin
      buzz_r      <= buzz_nxt;
      tbit_prev_r <= bz_tbit;
    end
  end

  // Pin mux: waveform owns the pin only while enabled
  // Port settings pass one flop too, so the pin stays registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_o_r  <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (pwm_output_enable_bit_r) begin
      pin_o_r  <= pwm_waveform;
      pin_oe_r <= 1'b1;
    end else begin
      pin_o_r  <= gpio_out;
      pin_oe_r <= gpio_oe;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (rd_stb) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata           = rdata_r;
  assign pwm_port_pin_o  = pin_o_r;
  assign pwm_port_pin_oe = pin_oe_r;
  assign buzzer_waveform = buzz_r;

endmodule

// ### tpb_asserts.sv
`timescale 1ns/10ps
module tpb_asserts #(
  parameter int AW = 8
) (
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0]    wdata,
  input wire logic          wr_stb,
  input wire logic          rd_stb,
  input wire logic [7:0]    rdata,
  input wire logic          gpio_out,
  input wire logic          gpio_oe,
  input wire logic          pwm_port_pin_o,
  input wire logic          pwm_port_pin_oe,
  input wire logic          buzzer_waveform
);
  logic       oen_r;
  logic       pol_r;
  logic       bzen_r;
  logic [9:0] duty_r;

  // Shadow of the software settings, so pins can be judged without the bodies
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {oen_r, pol_r, bzen_r, duty_r} <= '0;
    end else if (wr_stb) begin
      if (addr == 8'h11) {oen_r, pol_r} <= wdata[7:6];
      if (addr == 8'h15) bzen_r <= wdata[7];
      if (addr == 8'h13) duty_r[7:0] <= wdata;
      if (addr == 8'h17) duty_r[9:8] <= wdata[1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_rd_duty;
    rd_stb && addr == 8'h13;
  endsequence
  property p_rd_idle;
    !rd_stb |=> rdata == 8'h00;
  endproperty
  property p_duty_rd;
    s_rd_duty |=> rdata == 8'h00;
  endproperty
  property p_gpio;
    resetn && !oen_r |=> pwm_port_pin_o == $past(gpio_out) && pwm_port_pin_oe == $past(gpio_oe);
  endproperty
  property p_drive;
    oen_r |=> pwm_port_pin_oe;
  endproperty
  property p_pol;
    oen_r && duty_r == 10'h000 |=> pwm_port_pin_o == $past(pol_r);
  endproperty
  property p_bz_off;
    !bzen_r |=> !buzzer_waveform;
  endproperty
  property p_bz_start;
    $rose(bzen_r) |-> !buzzer_waveform;
  endproperty
  property p_bz_rise;
    $rose(buzzer_waveform) |-> $past(bzen_r);
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("rdata busy outside read slot");
  a_duty_rd: assert property (p_duty_rd) else $error("duty byte readable");
  a_gpio: assert property (p_gpio) else $error("pin not following port data");
  a_drive: assert property (p_drive) else $error("pin not driven by waveform");
  a_pol: assert property (p_pol) else $error("idle level wrong for polarity");
  a_bz_off: assert property (p_bz_off) else $error("buzzer active while disabled");
  a_bz_start: assert property (p_bz_start) else $error("buzzer not starting low");
  a_bz_rise: assert property (p_bz_rise) else $error("buzzer rose while disabled");
endmodule

bind tpb_timer tpb_asserts #(.AW(AW)) u_asserts (.clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .gpio_out, .gpio_oe, .pwm_port_pin_o, .pwm_port_pin_oe, .buzzer_waveform);

// ### tpb_pads.sv
`timescale 1ns/10ps
module tpb_pads (
  output logic      ext_clock_pin,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output wire       pad
);
  // Pull-up holds the pad when the block releases it
  assign pad = pin_oe ? pin_o : 1'b1;

  initial ext_clock_pin = 1'b0;

  // Stands still between bursts; 28 ns half period is unrelated to clk
  task automatic toggle(input int n);
    repeat (n) begin
      #28 ext_clock_pin = ~ext_clock_pin;
    end
    #28;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic       gpio_out = 1'b0;
  logic       gpio_oe = 1'b0;
  logic [7:0] rdata;
  logic       ext_clock_pin;
  logic       pin_o;
  logic       pin_oe;
  logic       buzz;
  logic       prev;
  logic [9:0] exp10;
  logic [7:0] c1v [3] = '{8'h01, 8'h03, 8'h07};
  wire        pad;
  int         n_fail = 0;
  int         cmp_count = 0;
  integer     seed = 91173;
  int         k;
  int         w;
  int         t;

  always #4 clk = ~clk;

  tpb_timer DUT (.clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .ext_clock_pin, .gpio_out,
    .gpio_oe, .pwm_port_pin_o(pin_o), .pwm_port_pin_oe(pin_oe), .buzzer_waveform(buzz));
  tpb_pads ext (.ext_clock_pin, .pin_o, .pin_oe, .pad);

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk8(rdata, exp);
  endtask
  // Enable edge to disable edge spans exactly n clk cycles of enabled counting
  task automatic run(input logic [7:0] c, input int n);
    wr(8'h11, c);
    repeat (n - 2) @(posedge clk);
    wr(8'h11, 8'h00);
  endtask
  function automatic logic [9:0] model(input logic [9:0] c, input logic [9:0] rl, input logic [1:0] md, input int n);
    for (int i = 0; i < n; i++) begin
      c = (c != 10'h000) ? c - 10'h001 : md[1] ? 10'h000 : md[0] ? rl : 10'h3ff;
    end
    return c;
  endfunction
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h3f);
    rd(8'h15, 8'h0f);
    wr(8'h14, 8'($random(seed)));
    rd(8'h14, 8'hff);
    rd(8'h13, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h12, 8'h0f);
    wr(8'h17, 8'h10);
    wr(8'h10, 8'h02);
    run(8'h05, 5);
    rd(8'h10, 8'hfd);
    for (int md = 0; md < 3; md++) begin
      w = 4 + ($random(seed) & 31);
      wr(8'h17, 8'h00);
      wr(8'h10, 8'h05);
      wr(8'h17, 8'h10);
      run(c1v[md] | {2'($random(seed)), 6'h00}, w);
      exp10 = model(10'h005, 10'h105, c1v[md][2:1], w);
      rd(8'h10, exp10[7:0]);
      rd(8'h10, exp10[7:0]);
    end
    wr(8'h17, 8'h30);
    for (int r = 0; r < 8; r++) begin
      k = 1 + ($random(seed) & 1);
      wr(8'h12, 8'h08 | 8'(r));
      wr(8'h12, 8'(r));
      wr(8'h10, 8'hff);
      run(8'h01, k << (r + 1));
      rd(8'h10, 8'hff - 8'(k));
    end
    wr(8'h12, 8'h0f);
    wr(8'h17, 8'h00);
    // Pin ends opposite to where it began, so both edge settings count the same k+1 edges
    for (int e = 0; e < 2; e++) begin
      k = 1 + ($random(seed) & 7);
      wr(8'h12, e ? 8'h3f : 8'h2f);
      wr(8'h10, 8'h40);
      wr(8'h11, 8'h01);
      ext.toggle(2 * k + 1);
      repeat (8) @(posedge clk);
      wr(8'h11, 8'h00);
      rd(8'h10, 8'h3f - 8'(k));
    end
    wr(8'h12, 8'h07);
    for (int s = 0; s < 16; s++) begin
      if (s == 8) wr(8'h12, 8'h0f);
      w = s < 8 ? 2 << s : 1 << (s - 8);
      wr(8'h11, 8'h01);
      wr(8'h15, 8'h80 | 8'(s));
      t = 0;
      prev = buzz;
      repeat (8 * w) begin
        @(posedge clk);
        #1 t += int'(buzz !== prev);
        prev = buzz;
      end
      chk1(t >= 7 && t <= 9, 1'b1);
      wr(8'h15, 8'h00);
      @(posedge clk);
      #1 chk1(buzz, 1'b0);
    end
    wr(8'h11, 8'h00);
    for (int i = 0; i < 4; i++) begin
      gpio_out <= 1'($random(seed));
      gpio_oe <= 1'($random(seed));
      wr(8'h17, i[0] ? 8'h03 : 8'h00);
      wr(8'h13, i[0] ? 8'hff : 8'h00);
      wr(8'h10, 8'h00);
      @(posedge clk);
      #1 chk1(pad, gpio_oe ? gpio_out : 1'b1);
      wr(8'h11, {1'b1, i[1], 6'h00});
      @(posedge clk);
      #1 chk1(pad, i[0] ^ i[1]);
      wr(8'h11, 8'h00);
    end
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h12, 8'h3f);
    rd(8'h14, 8'hff);
    finish_test;
  end
endmodule
